// ---- hw/prs_consts.vh ----
// What this block does
// - reference pressure is a signed 16-bit value in low and high byte registers
// - reference pressure low byte reads zero after reset
// - reference pressure captured and applied only while a capture function is on
// - signed 16-bit pressure offset in low and high byte registers, host writable
// - interrupt source bit 7 reads 1 while boot runs, else 0
// - interrupt source bit 2 reads 1 when any interrupt event was generated
// - interrupt source bit 1 set on a low differential pressure event
// - interrupt source bit 0 set on a high differential pressure event
// - queue status two bit 7 is 1 when fill count reaches threshold, resets 0
// - bit 6 is 1 once queue full and a sample overwritten, resets 0
// - bit 5 is 1 when queue completely filled, nothing overwritten, resets 0
// - data status bit 5 set when new temperature overwrites an unread one
// - data status bit 4 set when new pressure overwrites an unread one
// - data status bit 1 set when a new temperature result is generated
// - data status bit 0 set when a new pressure result is generated
// - data status register refreshed once per output data rate period
// - pressure result is signed 24-bit over three bytes, low byte lowest address
// - with compare and captures off, result equals measured minus stored offset
// - rate zero plus single trigger starts one measurement, self-clears, refreshes status
`ifndef PRS_CONSTS_VH
`define PRS_CONSTS_VH
`define PRS_ADDR_REF_LOW 8'h15
`define PRS_ADDR_REF_HIGH 8'h16
`define PRS_ADDR_OFS_LOW 8'h18
`define PRS_ADDR_OFS_HIGH 8'h19
`define PRS_ADDR_INT_SRC 8'h24
`define PRS_ADDR_QSTAT_ONE 8'h25
`define PRS_ADDR_QSTAT_TWO 8'h26
`define PRS_ADDR_DSTAT 8'h27
`define PRS_ADDR_RES_LOW 8'h28
`define PRS_ADDR_RES_MID 8'h29
`define PRS_ADDR_RES_HIGH 8'h2A
`define PRS_ADDR_TEMP_HIGH 8'h2C
`define PRS_BIT_BOOT 7
`define PRS_BIT_IA 2
`define PRS_BIT_LOW 1
`define PRS_BIT_HIGH 0
`define PRS_BIT_QLEVEL 7
`define PRS_BIT_QOVER 6
`define PRS_BIT_QFILL 5
`define PRS_BIT_TOR 5
`define PRS_BIT_POR 4
`define PRS_BIT_TDA 1
`define PRS_BIT_PDA 0
`define PRS_RST_BYTE 8'h00
`define PRS_RST_WORD 16'h0000
`define PRS_RST_RESULT 24'h000000
`define PRS_RATE_ONESHOT 3'h0
`define PRS_SEL_LOW 2'h0
`define PRS_SEL_MID 2'h1
`define PRS_SEL_HIGH 2'h2
`endif

// ---- hw/prs_result_store.v ----
`timescale 1ns/1ps
`include "prs_consts.vh"
module prs_result_store (
  input wire clk,
  input wire rst,
  input wire wrEn,
  input wire [23:0] wrData,
  input wire rdEn,
  input wire [1:0] rdSel,
  output reg [7:0] rdByte_q
);
  reg [23:0] live_q;
  reg [15:0] shadow_q;
  always @(posedge clk)
  begin
    if (rst)
    begin
      live_q <= `PRS_RST_RESULT;
      shadow_q <= `PRS_RST_WORD;
      rdByte_q <= `PRS_RST_BYTE;
    end
    else
    begin
      if (wrEn)
        live_q <= wrData;
      if (rdEn)
      begin
        case (rdSel)
          `PRS_SEL_LOW:
          begin
            rdByte_q <= live_q[7:0];
            shadow_q <= live_q[23:8];
          end
          `PRS_SEL_MID: rdByte_q <= shadow_q[7:0];
          `PRS_SEL_HIGH: rdByte_q <= shadow_q[15:8];
          default: rdByte_q <= `PRS_RST_BYTE;
        endcase
      end
    end
  end
endmodule

// ---- hw/prs_result_status_regs.v ----
`timescale 1ns/1ps
`include "prs_consts.vh"
module prs_result_status_regs (
  input wire clk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire regWrEn,
  input wire [7:0] regWrData,
  input wire regRdEn,
  output reg [7:0] regRdData_q,
  output reg regRdValid_q,
  input wire [2:0] outputRate,
  input wire singleMeasureTrigger,
  input wire zeroCaptureFunction,
  input wire refCaptureFunction,
  input wire thresholdCompareOn,
  input wire bootRunning,
  input wire lowEvent,
  input wire highEvent,
  input wire odrTick,
  input wire pressValid,
  input wire [23:0] measPress,
  input wire tempValid,
  input wire [7:0] queueCount,
  input wire queueLevelReached,
  input wire queueFull,
  input wire queueOverwrite,
  output reg measStart_q,
  output reg singleBusy_q,
  output reg [23:0] pressureResult_q
);
  function [23:0] sext16;
    input [15:0] v;
    begin
      sext16 = {{8{v[15]}}, v};
    end
  endfunction

  reg [15:0] refPress_q;
  reg [15:0] offset_q;
  reg captureArmed_q;
  reg lowFlag_q;
  reg highFlag_q;
  reg qLevel_q;
  reg qOver_q;
  reg qFill_q;
  reg [7:0] qCount_q;
  reg pendP_q;
  reg pendT_q;
  reg pDa_q;
  reg tDa_q;
  reg pOr_q;
  reg tOr_q;
  reg gotP_q;
  reg gotT_q;
  reg rdStage_q;
  reg resStage_q;
  reg [7:0] localByte_q;
  reg [7:0] localByte_d;
  reg [23:0] result_d;
  reg singleDone;
  reg refresh;
  reg isResult;
  reg [1:0] resSel;
  wire [7:0] resByte;

  wire captureOn = zeroCaptureFunction | refCaptureFunction;
  wire rdIntSrc = regRdEn && (regAddr == `PRS_ADDR_INT_SRC);
  wire rdPressHigh = regRdEn && (regAddr == `PRS_ADDR_RES_HIGH);
  wire rdTempHigh = regRdEn && (regAddr == `PRS_ADDR_TEMP_HIGH);

  // output value formation
  always @*
  begin
    if (captureOn)
      result_d = measPress - {refPress_q, `PRS_RST_BYTE};
    else if (thresholdCompareOn)
      result_d = measPress;
    else
      result_d = measPress - sext16(offset_q);
  end

  // single measurement completion
  always @*
  begin
    singleDone = singleBusy_q && (gotP_q || pressValid) && (gotT_q || tempValid);
    refresh = odrTick || singleDone;
  end

  // reference capture and offset
  always @(posedge clk)
  begin
    if (rst)
    begin
      refPress_q <= `PRS_RST_WORD;
      offset_q <= `PRS_RST_WORD;
      captureArmed_q <= 1'b0;
    end
    else
    begin
      if (!captureOn)
        captureArmed_q <= 1'b0;
      else if (!captureArmed_q && pressValid)
      begin
        refPress_q <= measPress[23:8];
        captureArmed_q <= 1'b1;
      end
      if (regWrEn && (regAddr == `PRS_ADDR_OFS_LOW))
        offset_q[7:0] <= regWrData;
      if (regWrEn && (regAddr == `PRS_ADDR_OFS_HIGH))
        offset_q[15:8] <= regWrData;
    end
  end

  // interrupt source and queue status
  always @(posedge clk)
  begin
    if (rst)
    begin
      lowFlag_q <= 1'b0;
      highFlag_q <= 1'b0;
      qLevel_q <= 1'b0;
      qOver_q <= 1'b0;
      qFill_q <= 1'b0;
      qCount_q <= `PRS_RST_BYTE;
    end
    else
    begin
      if (rdIntSrc)
      begin
        lowFlag_q <= 1'b0;
        highFlag_q <= 1'b0;
      end
      if (lowEvent)
        lowFlag_q <= 1'b1;
      if (highEvent)
        highFlag_q <= 1'b1;
      qLevel_q <= queueLevelReached;
      qOver_q <= queueFull && queueOverwrite;
      qFill_q <= queueFull && !queueOverwrite;
      qCount_q <= queueCount;
    end
  end

  // single measurement sequencing
  always @(posedge clk)
  begin
    if (rst)
    begin
      singleBusy_q <= 1'b0;
      measStart_q <= 1'b0;
      gotP_q <= 1'b0;
      gotT_q <= 1'b0;
    end
    else
    begin
      measStart_q <= 1'b0;
      if (singleBusy_q)
      begin
        if (pressValid)
          gotP_q <= 1'b1;
        if (tempValid)
          gotT_q <= 1'b1;
        if (singleDone)
        begin
          singleBusy_q <= 1'b0;
          gotP_q <= 1'b0;
          gotT_q <= 1'b0;
        end
      end
      else if (singleMeasureTrigger && (outputRate == `PRS_RATE_ONESHOT))
      begin
        singleBusy_q <= 1'b1;
        measStart_q <= 1'b1;
      end
    end
  end

  // data status flags, applied at each refresh
  always @(posedge clk)
  begin
    if (rst)
    begin
      pendP_q <= 1'b0;
      pendT_q <= 1'b0;
      pDa_q <= 1'b0;
      tDa_q <= 1'b0;
      pOr_q <= 1'b0;
      tOr_q <= 1'b0;
    end
    else
    begin
      if (refresh)
      begin
        pendP_q <= 1'b0;
        pendT_q <= 1'b0;
      end
      if (pressValid && !refresh)
        pendP_q <= 1'b1;
      if (tempValid && !refresh)
        pendT_q <= 1'b1;
      if (rdPressHigh)
      begin
        pDa_q <= 1'b0;
        pOr_q <= 1'b0;
      end
      if (rdTempHigh)
      begin
        tDa_q <= 1'b0;
        tOr_q <= 1'b0;
      end
      if (refresh && (pendP_q || pressValid))
      begin
        pDa_q <= 1'b1;
        if (pDa_q && !rdPressHigh)
          pOr_q <= 1'b1;
      end
      if (refresh && (pendT_q || tempValid))
      begin
        tDa_q <= 1'b1;
        if (tDa_q && !rdTempHigh)
          tOr_q <= 1'b1;
      end
    end
  end

  // pressure result register
  always @(posedge clk)
  begin
    if (rst)
      pressureResult_q <= `PRS_RST_RESULT;
    else if (pressValid)
      pressureResult_q <= result_d;
  end

  prs_result_store u_store (
    .clk(clk),
    .rst(rst),
    .wrEn(pressValid),
    .wrData(result_d),
    .rdEn(regRdEn && isResult),
    .rdSel(resSel),
    .rdByte_q(resByte)
  );

  // register read decode
  always @*
  begin
    localByte_d = `PRS_RST_BYTE;
    isResult = 1'b0;
    resSel = `PRS_SEL_LOW;
    case (regAddr)
      `PRS_ADDR_REF_LOW: localByte_d = refPress_q[7:0];
      `PRS_ADDR_REF_HIGH: localByte_d = refPress_q[15:8];
      `PRS_ADDR_OFS_LOW: localByte_d = offset_q[7:0];
      `PRS_ADDR_OFS_HIGH: localByte_d = offset_q[15:8];
      `PRS_ADDR_INT_SRC:
      begin
        localByte_d[`PRS_BIT_BOOT] = bootRunning;
        localByte_d[`PRS_BIT_IA] = lowFlag_q | highFlag_q;
        localByte_d[`PRS_BIT_LOW] = lowFlag_q;
        localByte_d[`PRS_BIT_HIGH] = highFlag_q;
      end
      `PRS_ADDR_QSTAT_ONE: localByte_d = qCount_q;
      `PRS_ADDR_QSTAT_TWO:
      begin
        localByte_d[`PRS_BIT_QLEVEL] = qLevel_q;
        localByte_d[`PRS_BIT_QOVER] = qOver_q;
        localByte_d[`PRS_BIT_QFILL] = qFill_q;
      end
      `PRS_ADDR_DSTAT:
      begin
        localByte_d[`PRS_BIT_TOR] = tOr_q;
        localByte_d[`PRS_BIT_POR] = pOr_q;
        localByte_d[`PRS_BIT_TDA] = tDa_q;
        localByte_d[`PRS_BIT_PDA] = pDa_q;
      end
      `PRS_ADDR_RES_LOW:
      begin
        isResult = 1'b1;
        resSel = `PRS_SEL_LOW;
      end
      `PRS_ADDR_RES_MID:
      begin
        isResult = 1'b1;
        resSel = `PRS_SEL_MID;
      end
      `PRS_ADDR_RES_HIGH:
      begin
        isResult = 1'b1;
        resSel = `PRS_SEL_HIGH;
      end
      default: localByte_d = `PRS_RST_BYTE;
    endcase
  end

  // two-stage read return
  always @(posedge clk)
  begin
    if (rst)
    begin
      rdStage_q <= 1'b0;
      resStage_q <= 1'b0;
      localByte_q <= `PRS_RST_BYTE;
      regRdData_q <= `PRS_RST_BYTE;
      regRdValid_q <= 1'b0;
    end
    else
    begin
      rdStage_q <= regRdEn;
      resStage_q <= isResult;
      if (regRdEn)
        localByte_q <= localByte_d;
      regRdValid_q <= rdStage_q;
      if (rdStage_q)
        regRdData_q <= resStage_q ? resByte : localByte_q;
    end
  end
endmodule

// ---- test/prs_asserts.sv ----
`timescale 1ns/1ps
module prs_asserts (
  input wire clk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire regRdEn,
  input wire [7:0] regRdData_q,
  input wire regRdValid_q,
  input wire [2:0] outputRate,
  input wire singleMeasureTrigger,
  input wire bootRunning,
  input wire queueLevelReached,
  input wire queueFull,
  input wire queueOverwrite,
  input wire measStart_q,
  input wire singleBusy_q,
  input wire [23:0] pressureResult_q
);
  wire [2:0] queueIn = {queueLevelReached, queueFull, queueOverwrite};
  wire startOk = singleMeasureTrigger && outputRate == 3'h0 && !singleBusy_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_readLatency; regRdValid_q == $past(regRdEn, 2); endproperty
  a_readLatency: assert property (p_readLatency) else $error("read answer late");
  property p_singleStart; startOk |=> measStart_q && singleBusy_q; endproperty
  a_singleStart: assert property (p_singleStart) else $error("single start missing");
  property p_singleRefused; !startOk |=> !measStart_q; endproperty
  a_singleRefused: assert property (p_singleRefused) else $error("start without trigger");
  property p_busyRise; $rose(singleBusy_q) |-> measStart_q; endproperty
  a_busyRise: assert property (p_busyRise) else $error("busy without start");
  property p_bootBit;
    (regRdEn && regAddr == 8'h24) ##1 $stable(bootRunning) [*2] |-> regRdData_q[7] == bootRunning;
  endproperty
  a_bootBit: assert property (p_bootBit) else $error("boot bit wrong");
  property p_intSource;
    regRdEn && regAddr == 8'h24 |-> ##2 regRdData_q[6:3] == 4'h0 && regRdData_q[2] == |regRdData_q[1:0];
  endproperty
  a_intSource: assert property (p_intSource) else $error("active bit wrong");
  property p_queueBits;
    (regRdEn && regAddr == 8'h26 && $stable(queueIn)) ##1 $stable(queueIn) [*2]
      |-> regRdData_q[7:5] == {queueIn[2], queueIn[1] & queueIn[0], queueIn[1] & ~queueIn[0]};
  endproperty
  a_queueBits: assert property (p_queueBits) else $error("queue bits wrong");
  property p_resetClear; $fell(rst) |-> pressureResult_q == 24'h000000 && !singleBusy_q; endproperty
  a_resetClear: assert property (p_resetClear) else $error("outputs not cleared");
endmodule
bind prs_result_status_regs prs_asserts chk (.clk(clk), .rst(rst), .regAddr(regAddr), .regRdEn(regRdEn),
  .regRdData_q(regRdData_q), .regRdValid_q(regRdValid_q), .outputRate(outputRate),
  .singleMeasureTrigger(singleMeasureTrigger), .bootRunning(bootRunning), .queueLevelReached(queueLevelReached),
  .queueFull(queueFull), .queueOverwrite(queueOverwrite), .measStart_q(measStart_q),
  .singleBusy_q(singleBusy_q), .pressureResult_q(pressureResult_q));

// ---- test/prs_host_model.sv ----
`timescale 1ns/1ps
module prs_host_model (
  input wire clk,
  output reg [7:0] regAddr,
  output reg regWrEn,
  output reg [7:0] regWrData,
  output reg regRdEn
);
  initial
  begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // released lines show the inverse value
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task rd(input [7:0] a);
    @(negedge clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
  endtask
endmodule

// ---- test/prs_testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg clk, rst, trig, zeroCap, refCap, cmpOn, boot, lowEv, highEv, output_rate, pv, tv, qLvl, qFull, qOvw;
  reg [2:0] outputRate;
  reg [7:0] qCnt;
  reg [15:0] ofs;
  reg [23:0] meas;
  reg [16:0] notes[$];
  reg [16:0] note;
  wire [7:0] regAddr, regWrData, rdData;
  wire regWrEn, regRdEn, rdValid, busy;
  wire [23:0] pres;
  integer n_errors, check_count, i;
  prs_host_model host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));
  prs_result_status_regs dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData_q(rdData), .regRdValid_q(rdValid), .outputRate(outputRate),
    .singleMeasureTrigger(trig), .zeroCaptureFunction(zeroCap), .refCaptureFunction(refCap),
    .thresholdCompareOn(cmpOn), .bootRunning(boot), .lowEvent(lowEv), .highEvent(highEv), .odrTick(output_rate),
    .pressValid(pv), .measPress(meas), .tempValid(tv), .queueCount(qCnt), .queueLevelReached(qLvl),
    .queueFull(qFull), .queueOverwrite(qOvw), .measStart_q(), .singleBusy_q(busy), .pressureResult_q(pres));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    notes.push_back({1'b1, a, e});
    host.rd(a);
    repeat (2) @(negedge clk);
  endtask
  task rdRes(input [23:0] v);
    rd(8'h28, v[7:0]);
    rd(8'h29, v[15:8]);
    rd(8'h2A, v[23:16]);
    check_count = check_count + 1;
    if (pres !== v)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED pressureResult expected %h seen %h", v, pres);
    end
  endtask
  // bits: trigger, tick, pressure, temperature, low, high
  task pulse(input [5:0] m);
    @(negedge clk);
    {trig, output_rate, pv, tv, lowEv, highEv} = m;
    @(negedge clk);
    {trig, output_rate, pv, tv, lowEv, highEv} = 6'h00;
  endtask
  always @(negedge clk)
    if (rdValid === 1'b1 && notes.size() > 0)
    begin
      note = notes.pop_front();
      check_count = check_count + 1;
      if (note[16] && rdData !== note[7:0])
      begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED reg %h expected %h seen %h", note[15:8], note[7:0], rdData);
      end
    end
    else if (rdValid === 1'b1)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED read answer expected none seen %h", rdData);
    end
  initial
  begin
    {rst, trig, zeroCap, refCap, cmpOn, boot, lowEv, highEv, output_rate, pv, tv, qLvl, qFull, qOvw} = 14'h2000;
    outputRate = 3'h1;
    qCnt = 8'h00;
    meas = 24'h000000;
    n_errors = 0;
    check_count = 0;
    i = $urandom(88070);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 5; i = i + 1)
      rd(40'h1518192730 >> (32 - 8 * i), 8'h00);
    ofs = $urandom;
    host.wr(8'h18, ofs[7:0]);
    host.wr(8'h19, ofs[15:8]);
    rd(8'h18, ofs[7:0]);
    rd(8'h19, ofs[15:8]);
    meas = $urandom;
    pulse(6'h1C);
    rd(8'h27, 8'h03);
    rdRes(meas - {{8{ofs[15]}}, ofs});
    rd(8'h27, 8'h02);
    pulse(6'h1C);
    rd(8'h27, 8'h23);
    pulse(6'h18);
    rd(8'h27, 8'h33);
    rdRes(meas - {{8{ofs[15]}}, ofs});
    notes.push_back({1'b0, 16'h2C00});
    host.rd(8'h2C);
    repeat (2) @(negedge clk);
    rd(8'h27, 8'h00);
    boot = 1'b1;
    rd(8'h24, 8'h80);
    boot = 1'b0;
    pulse(6'h02);
    rd(8'h24, 8'h06);
    rd(8'h24, 8'h00);
    pulse(6'h01);
    rd(8'h24, 8'h05);
    qCnt = $urandom;
    {qLvl, qFull, qOvw} = 3'h6;
    rd(8'h25, qCnt);
    rd(8'h26, 8'hA0);
    qOvw = 1'b1;
    rd(8'h26, 8'hC0);
    {qLvl, qFull, qOvw} = 3'h0;
    rd(8'h26, 8'h00);
    pulse(6'h20);
    outputRate = 3'h0;
    pulse(6'h20);
    pulse(6'h0C);
    for (i = 0; i < 20 && busy !== 1'b0; i = i + 1)
      @(negedge clk);
    if (busy !== 1'b0)
      n_errors = n_errors + 1;
    else
    begin
      rd(8'h27, 8'h03);
      cmpOn = 1'b1;
      meas = $urandom;
      pulse(6'h08);
      rdRes(meas);
      cmpOn = 1'b0;
      zeroCap = 1'b1;
      pulse(6'h08);
      pulse(6'h08);
      rd(8'h16, meas[23:16]);
      rd(8'h15, meas[15:8]);
      rdRes({16'h0000, meas[7:0]});
      for (i = 0; i < 10 && notes.size() > 0; i = i + 1)
        @(negedge clk);
      if (notes.size() > 0)
        n_errors = n_errors + 1;
    end
    report_and_stop;
  end
endmodule
